/* verilog/low_side_relay_driver_ctrl.sv */
// Overview of operation
// - Drivers work only in Normal mode; Sleep and Stop force both off.
// - Control bit 7 enables overtemperature interrupt; bit 6 reads zero.
// - Channel-select bits 5 and 4 pick PWM channel 0 or 1.
// - PWM bits 3 and 2 gate the driver with its chosen channel.
// - Enable bits 1 and 0 act only after a correct key write.
// - Key register holds four bits; value 5 permits driver control.
// - Status bit 7 shows overtemperature; both drivers held off meanwhile.
// - Reading status clears the latched overtemperature interrupt flag.
// - Status bits 3 and 2 report current limit, read only.
// - Status bits 1 and 0 report open load, never while off.
// - Registers decode at offsets 0x30, 0x31 and 0x32.
// - Offsets add to base 0x200 blocking or 0x300 non-blocking.
// - Each switch follows its own enable bit, subject to key and protection.
// - Regulator overvoltage clears both driver enable bits.
// - After overtemperature, drivers stay off until a control write without it.
`include "ls_drv_defines.svh"

module low_side_relay_driver_ctrl
    import ls_drv_pkg::*;
#(
    parameter int NUM_DRV = 2
)
(
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire power_mode_t power_mode_in,
    input  wire bus_req_t    bus_req_in,
    output logic [7:0]       bus_rdata_out,
    input  wire logic [1:0]  pwm_in,
    input  wire sense_t      sense_in,
    input  wire logic        regulator_overvoltage_in,
    output logic             relay_driver_one_out,
    output logic             relay_driver_two_out,
    output logic             overtemp_irq_flag_out,
    output logic             overtemp_irq_enable_out
);
    logic [7:0]         control_r;
    logic [3:0]         key_r;
    logic               ot_lock_r;
    logic               irq_flag_r;
    logic               ot_seen_r;
    logic               allow;
    logic               mode_ok;
    logic               key_ok;
    logic               protect_ok;
    logic               ot_rise;
    logic [1:0]         cl_q;
    logic [1:0]         ol_q;
    logic [NUM_DRV-1:0] en_bits;
    logic [NUM_DRV-1:0] gate_bits;
    logic [NUM_DRV-1:0] sel_bits;
    logic [NUM_DRV-1:0] drive;
    logic [7:0]         rdata_nxt;
    logic               rd_any;
    logic               wr_ctrl;
    logic               wr_key;
    logic               rd_stat;

    // Each driver owns fixed control and status bits; other counts have nowhere to map
    if (NUM_DRV != 2) begin : g_bad_num_drv
        $error("NUM_DRV must be 2");
    end

    // Strobe decode lives in one place, shared by the status read and the writes; read data uses its own case
    function automatic logic hit(input bus_req_t req, input logic [7:0] off);
        hit = req.sel & (req.addr == off);
    endfunction : hit

    function automatic logic is_normal(input power_mode_t mode);
        is_normal = (mode == MODE_NORMAL);
    endfunction : is_normal

    // Spare bits are packed as zeros here so every status read sees one layout
    function automatic logic [7:0] status_word(input logic ot, input logic [1:0] cl,
                                               input logic [1:0] ol);
        status_word = {ot, 3'h0, cl, ol};
    endfunction : status_word

    assign wr_ctrl = bus_req_in.wr & hit(bus_req_in, `LS_OFF_CONTROL);
    assign wr_key  = bus_req_in.wr & hit(bus_req_in, `LS_OFF_KEY);
    assign rd_stat = bus_req_in.rd & hit(bus_req_in, `LS_OFF_STATUS);

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            control_r <= `LS_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                control_r <= bus_req_in.wdata & `LS_CTRL_WMASK;
            end
            if (regulator_overvoltage_in) begin
                control_r[`LS_BIT_EN2] <= 1'b0;
                control_r[`LS_BIT_EN1] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            key_r <= `LS_KEY_RESET;
        end else if (regulator_overvoltage_in) begin
            key_r <= `LS_KEY_RESET;
        end else if (wr_key) begin
            key_r <= bus_req_in.wdata[3:0];
        end
    end

    // Lock survives the end of the overheat until software rewrites control
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ot_lock_r <= 1'b0;
        end else if (sense_in.overtemp) begin
            ot_lock_r <= 1'b1;
        end else if (wr_ctrl) begin
            ot_lock_r <= 1'b0;
        end
    end

    // Flag sets on the rising edge of overheat; a new event beats a clearing read
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ot_seen_r  <= 1'b0;
            irq_flag_r <= 1'b0;
        end else begin
            ot_seen_r <= sense_in.overtemp;
            if (ot_rise) begin
                irq_flag_r <= 1'b1;
            end else if (rd_stat) begin
                irq_flag_r <= 1'b0;
            end
        end
    end

    assign mode_ok    = is_normal(power_mode_in);
    assign key_ok     = (key_r == `LS_KEY_VALUE);
    // Live overheat blocks at once; the lock keeps the block until software acts
    assign protect_ok = ~ot_lock_r & ~sense_in.overtemp;
    assign allow      = mode_ok & key_ok & protect_ok;
    assign ot_rise    = sense_in.overtemp & ~ot_seen_r;
    assign rd_any     = bus_req_in.sel & bus_req_in.rd;

    assign en_bits   = {control_r[`LS_BIT_EN2], control_r[`LS_BIT_EN1]};
    assign gate_bits = {control_r[`LS_BIT_PWM2], control_r[`LS_BIT_PWM1]};
    assign sel_bits  = {control_r[`LS_BIT_CS2], control_r[`LS_BIT_CS1]};

    for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
        ls_drv_channel u_ls_drv_channel (
            .clk_sys_in    (clk_sys_in),
            .sys_rst_in    (sys_rst_in),
            .allow_in      (allow),
            .enable_in     (en_bits[i]),
            .pwm_gate_in   (gate_bits[i]),
            .chan_sel_in   (sel_bits[i]),
            .pwm_in        (pwm_in),
            .cur_lim_in    (sense_in.current_limit[i]),
            .open_load_in  (sense_in.open_load[i]),
            .drive_out     (drive[i]),
            .cur_lim_out   (cl_q[i]),
            .open_load_out (ol_q[i])
        );
    end

    assign relay_driver_one_out = drive[0];
    assign relay_driver_two_out = drive[1];

    always_comb begin
        case (bus_req_in.addr)
            `LS_OFF_CONTROL: rdata_nxt = control_r;
            `LS_OFF_STATUS:  rdata_nxt = status_word(sense_in.overtemp, cl_q, ol_q);
            `LS_OFF_KEY:     rdata_nxt = {4'h0, key_r};
            default:         rdata_nxt = 8'h00;
        endcase
    end

    // Data holds between reads, so a master may pick it up any cycle later
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_rdata_out <= 8'h00;
        end else if (rd_any) begin
            bus_rdata_out <= rdata_nxt;
        end
    end

    assign overtemp_irq_flag_out   = irq_flag_r;
    assign overtemp_irq_enable_out = control_r[`LS_BIT_OTIE];
endmodule : low_side_relay_driver_ctrl

/* verilog/ls_drv_defines.svh */
`ifndef LS_DRV_DEFINES_SVH
`define LS_DRV_DEFINES_SVH

`define LS_OFF_CONTROL      8'h30
`define LS_OFF_STATUS       8'h31
`define LS_OFF_KEY          8'h32
`define LS_BASE_BLOCKING    16'h0200
`define LS_BASE_NONBLOCKING 16'h0300
`define LS_KEY_VALUE        4'h5
`define LS_CTRL_RESET       8'h00
`define LS_KEY_RESET        4'h0
`define LS_CTRL_WMASK       8'hBF
`define LS_BIT_OTIE         7
`define LS_BIT_CS2          5
`define LS_BIT_CS1          4
`define LS_BIT_PWM2         3
`define LS_BIT_PWM1         2
`define LS_BIT_EN2          1
`define LS_BIT_EN1          0
`define LS_BIT_OTC          7

`endif

/* verilog/ls_drv_pkg.sv */
package ls_drv_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SLEEP,
        MODE_STOP
    } power_mode_t;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [1:0] current_limit;
        logic [1:0] open_load;
        logic       overtemp;
    } sense_t;
endpackage : ls_drv_pkg

/* verilog/ls_drv_channel.sv */
`include "ls_drv_defines.svh"

module ls_drv_channel
    import ls_drv_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic sys_rst_in,
    input  wire logic allow_in,
    input  wire logic enable_in,
    input  wire logic pwm_gate_in,
    input  wire logic chan_sel_in,
    input  wire logic [1:0] pwm_in,
    input  wire logic cur_lim_in,
    input  wire logic open_load_in,
    output logic      drive_out,
    output logic      cur_lim_out,
    output logic      open_load_out
);
    logic pwm_level;
    logic drive_nxt;

    always_comb begin
        pwm_level = chan_sel_in ? pwm_in[1] : pwm_in[0];
        drive_nxt = allow_in & enable_in & (~pwm_gate_in | pwm_level);
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            drive_out <= 1'b0;
        end else begin
            drive_out <= drive_nxt;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur_lim_out   <= 1'b0;
            open_load_out <= 1'b0;
        end else begin
            cur_lim_out   <= cur_lim_in;
            // Sensing is meaningless with the switch open, so mask it off
            open_load_out <= open_load_in & drive_nxt;
        end
    end
endmodule : ls_drv_channel

/* tb/ls_drv_monitor.sv */
module ls_drv_monitor
    import ls_drv_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire power_mode_t power_mode_in,
    input  wire bus_req_t    bus_req_in,
    input  wire logic [7:0]  bus_rdata_out,
    input  wire sense_t      sense_in,
    input  wire logic        regulator_overvoltage_in,
    input  wire logic        relay_driver_one_out,
    input  wire logic        relay_driver_two_out,
    input  wire logic        overtemp_irq_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    logic rd_st, off, wr_ct, w7;
    assign rd_st = bus_req_in.sel && bus_req_in.rd && bus_req_in.addr == 8'h31;
    assign wr_ct = bus_req_in.sel && bus_req_in.wr && bus_req_in.addr == 8'h30;
    assign off   = !relay_driver_one_out && !relay_driver_two_out;
    assign w7    = bus_req_in.wdata[7];
    // Three cycles let a registered drive settle after its cause
    sequence s_ov_quiet; regulator_overvoltage_in ##1 (!bus_req_in.wr) [*3]; endsequence
    property p_mode; (power_mode_in != MODE_NORMAL) [*3] |-> off; endproperty
    property p_ot; sense_in.overtemp [*3] |-> off; endproperty
    property p_ie; wr_ct |=> overtemp_irq_enable_out == $past(w7); endproperty
    property p_zero; rd_st |=> bus_rdata_out[6:4] == 3'h0; endproperty
    property p_ol; (!relay_driver_one_out) [*3] ##0 rd_st |=> !bus_rdata_out[0]; endproperty
    property p_unmap;
        bus_req_in.sel && bus_req_in.rd && bus_req_in.addr > 8'h32 |=> bus_rdata_out == 8'h00;
    endproperty
    property p_ov; s_ov_quiet |-> off; endproperty
    a_mode: assert property (p_mode) else $error("drive on outside normal mode");
    a_ot: assert property (p_ot) else $error("drive on during overtemperature");
    a_ie: assert property (p_ie) else $error("irq enable not written");
    a_zero: assert property (p_zero) else $error("status spare bits set");
    a_ol: assert property (p_ol) else $error("open load while off");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_ov: assert property (p_ov) else $error("drive on after overvoltage");
endmodule : ls_drv_monitor

bind low_side_relay_driver_ctrl ls_drv_monitor u_ls_drv_monitor (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .power_mode_in(power_mode_in),
    .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .sense_in(sense_in),
    .regulator_overvoltage_in(regulator_overvoltage_in),
    .relay_driver_one_out(relay_driver_one_out), .relay_driver_two_out(relay_driver_two_out),
    .overtemp_irq_enable_out(overtemp_irq_enable_out));

/* tb/mcu_bus_model.sv */
module mcu_bus_model
    import ls_drv_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    output bus_req_t        req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clk_sys_in);
        req_out = '{1'b1, w, !w, a, d};
        @(negedge clk_sys_in);
        // Released lines carry a changed pattern so stale values cannot pass
        req_out = '{1'b0, 1'b0, 1'b0, ~a, ~d};
        @(negedge clk_sys_in);
        q = rdata_in;
    endtask : xfer
endmodule : mcu_bus_model

/* tb/testbench.sv */
module testbench
    import ls_drv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] w; logic [1:0] p; logic o1, o2; logic [7:0] rb;} row_t;
    row_t rows [7] = '{'{8'h03, 2'b00, 1, 1, 8'h03}, '{8'h0F, 2'b01, 1, 1, 8'h0F},
        '{8'h0F, 2'b10, 0, 0, 8'h0F}, '{8'h3F, 2'b10, 1, 1, 8'h3F},
        '{8'h1F, 2'b01, 0, 1, 8'h1F}, '{8'hC1, 2'b00, 1, 0, 8'h81}, '{8'h00, 2'b11, 0, 0, 8'h00}};
    logic clk, rst, ov, r1, r2, flag, ien;
    logic [7:0] rdata, q;
    logic [1:0] pwm;
    power_mode_t mode;
    bus_req_t req;
    sense_t sense;
    int bad_count = 0, n_checks = 0, cyc = 0;
    low_side_relay_driver_ctrl u_low_side_relay_driver_ctrl (.clk_sys_in(clk), .sys_rst_in(rst),
        .power_mode_in(mode), .bus_req_in(req), .bus_rdata_out(rdata), .pwm_in(pwm),
        .sense_in(sense), .regulator_overvoltage_in(ov), .relay_driver_one_out(r1),
        .relay_driver_two_out(r2), .overtemp_irq_flag_out(flag), .overtemp_irq_enable_out(ien));
    mcu_bus_model u_mcu_bus_model (.clk_sys_in(clk), .rdata_in(rdata), .req_out(req));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d); u_mcu_bus_model.xfer(1'b1, a, d, q); endtask : wr
    task automatic rd(input logic [7:0] a, e);
        u_mcu_bus_model.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rd
    task automatic dr(input logic [1:0] e);
        repeat (3) @(negedge clk);
        chk({6'h0, r2, r1}, {6'h0, e});
    endtask : dr
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        {rst, ov, pwm, sense, mode} = {1'b1, 1'b0, 2'b00, 5'h00, MODE_NORMAL};
        repeat (2) @(negedge clk);
        rst = 0;
        wr(8'h32, 8'h05);
        foreach (rows[i]) begin
            pwm = rows[i].p;
            wr(8'h30, rows[i].w);
            dr({rows[i].o2, rows[i].o1});
            rd(8'h30, rows[i].rb);
            chk({7'h0, ien}, {7'h0, rows[i].w[7]});
        end
        wr(8'h30, 8'h83);
        for (int m = 1; m < 3; m++) begin
            mode = power_mode_t'(m);
            dr(2'b00);
        end
        mode = MODE_NORMAL;
        dr(2'b11);
        sense = 5'h1E;
        rd(8'h31, 8'h0F);
        wr(8'h31, 8'hFF);
        rd(8'h31, 8'h0F);
        rd(8'h33, 8'h00);
        sense.overtemp = 1;
        dr(2'b00);
        chk({7'h0, flag}, 8'h01);
        rd(8'h31, 8'h8C);
        chk({7'h0, flag}, 8'h00);
        sense.overtemp = 0;
        dr(2'b00);
        wr(8'h30, 8'h83);
        dr(2'b11);
        ov = 1;
        dr(2'b00);
        ov = 0;
        rd(8'h30, 8'h80);
        wr(8'h30, 8'h83);
        dr(2'b00);
        wr(8'h32, 8'h04);
        wr(8'h30, 8'h83);
        dr(2'b00);
        wr(8'h32, 8'hF5);
        rd(8'h32, 8'h05);
        dr(2'b11);
        rst = 1;
        @(negedge clk);
        rst = 0;
        rd(8'h30, 8'h00);
        rd(8'h32, 8'h00);
        finish_test();
    end
endmodule : testbench
